// File: design/hsr_cfg.svh
// offsets, field positions, reset values and timing counts of the host port
`ifndef HSR_CFG_SVH
`define HSR_CFG_SVH

`define HSR_OFF_STAGING     8'hf4
`define HSR_OFF_IND_INDEX   8'hf8
`define HSR_OFF_IND_WINDOW  8'hfc
`define HSR_OFF_POWER       8'hb0
`define HSR_OFF_FIFO_XFER   8'hc0
`define HSR_GEN_COUNT       44
`define HSR_IND_COUNT       16

`define HSR_STAGING_RESET   32'h0f0a_0500
`define HSR_POWER_RESET     32'h0000_0000

`define HSR_BIT_LPS_STATE   0
`define HSR_BIT_CLK_IDLE    1
`define HSR_BIT_PHY_LINK    2
`define HSR_BIT_LINK_ON     3
`define HSR_BIT_CLK_ACT     4
`define HSR_BIT_EN_PHY_LINK 8
`define HSR_BIT_EN_LINK_ON  9
`define HSR_BIT_EN_CLK_ACT  10
`define HSR_BIT_EN_CLK_IDLE 11
`define HSR_BIT_SOFT_PD     16

`define HSR_CLK_MHZ         50
`define HSR_WAIT_MAX_NS     120
`define HSR_WAIT_CYCLES     ((`HSR_WAIT_MAX_NS * `HSR_CLK_MHZ) / 1000)

`endif

// File: design/hsr_pkg.sv
// types shared by the host shadow register access port
package hsr_pkg;

    typedef struct packed {
        logic        cs_n;   // chip select, active low
        logic        rd_n;   // read strobe, active low
        logic        wr_n;   // write strobe, active low
        logic [8:0]  addr;   // [8] snapshot_update_line, [7:2] index
        logic [15:0] data;   // write data from host
    } hsr_host_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } hsr_quad_t;

    typedef enum logic [1:0] {
        HSR_IDLE   = 2'b00,
        HSR_READ   = 2'b01,
        HSR_WRITE  = 2'b10
    } hsr_acc_t;

endpackage

// File: design/hsr_host_port.sv
// host shadow register access port with power-management register
//
// Operation
// [R1] 8-bit read: lane lines pick which staging byte goes out.
// [R2] 16-bit read: byte_lane_select_hi alone picks upper or lower half.
// [R3] read lane selection is purely combinational.
// [R4] read with update line high copies indexed register into staging.
// [R5] refreshed staging value is shown in the same access.
// [R6] reads without update return staging unchanged, any order, any count.
// [R7] no need to read all lanes; single updating byte read is complete.
// [R8] buffer and protection registers only through index/window pair.
// [R9] write commits the full 32-bit staging value in one clock.
// [R10] 8-bit write loads the lane chosen by the two low lines.
// [R11] 16-bit write loads the half chosen by byte_lane_select_hi.
// [R12] each write cycle updates exactly one byte or one word.
// [R13] commit carries unwritten lanes as left in staging.
// [R14] lanes may be written in any order; later writes replace.
// [R15] quadlets move between fifos and transfer register without host.
// [R16] one-byte read-modify-write leaves other bytes unchanged.
// [R17] power register bypasses staging, read combinationally.
// [R18] lps_state_flag mirrors the link power status signal.
// [R19] clock_idle_flag shows stopped clock; interrupt acknowledged by 1.
// [R20] event flags latch at 1; cleared only by writing 1.
// [R21] enables turn matching flags into interrupts.
// [R22] soft_powerdown stops driving lps; does not mirror powerdown_pin.
// [R23] wait_extend stretches an updating access, at most 120 ns.
// [R24] staging holds the preset pattern after reset.
// [R25] powered down, only the power register is accessible.
// [R26] reading the receive queue location pops its oldest quadlet.
// [R27] host_irq_n low while any flag and its enable are both set.
`timescale 1ns/10ps
`default_nettype none
`include "hsr_cfg.svh"

module hsr_host_port
    import hsr_pkg::*;
(
    input  wire logic          sys_clk,        // system clock, 50 MHz
    input  wire logic          rst_n,          // async reset, active low
    input  wire hsr_host_req_t host_req,       // host bus pins
    input  wire logic          bus16_mode,     // 1: 16-bit data bus
    output logic        [15:0] host_rdata,     // read data to host
    output logic               host_rdata_oe,  // drive data bus
    output logic               wait_extend,    // cycle extension, high
    output logic               host_irq_n,     // interrupt, active low
    input  wire logic          lps_active,     // link power status seen
    input  wire logic          clock_idle,     // system clock monitor
    input  wire logic          phy_link_evt,   // phy-link event pulse
    input  wire logic          link_on_evt,    // link-on event pulse
    input  wire logic          clk_act_evt,    // clock activity pulse
    input  wire logic          powerdown_pin,  // power-down pin
    output logic               lps_drive,      // drive lps to phy
    input  wire hsr_quad_t     rx_head,        // receive queue head
    output logic               rx_pop,         // remove receive head
    output hsr_quad_t          tx_out,         // quadlet to tx fifo
    input  wire logic          tx_ready        // tx fifo accepts
);

    localparam logic [2:0] WAIT_CYC = 3'(`HSR_WAIT_CYCLES);

    logic [31:0] staging;
    logic [31:0] ind_index;
    logic [31:0] power_reg;
    logic [31:0] gen_reg [`HSR_GEN_COUNT];
    logic [31:0] ind_reg [`HSR_IND_COUNT];
    hsr_acc_t    acc_state;
    hsr_acc_t    next_acc_state;
    wire logic [3:0] irq_src;
    logic [2:0]  wait_cnt;
    logic [31:0] target_val;
    logic [31:0] next_staging;
    logic [31:0] lane_mask;
    logic [31:0] lane_data;
    logic [31:0] power_view;
    logic [7:0]  byte_addr;

    // big-endian lanes: lane 0 is bits 31:24
    function automatic logic [31:0] lane_bits(input logic b16,
                                              input logic [1:0] sel);
        logic [31:0] m;
        m = 32'h0000_0000;
        if (b16)
            m = sel[1] ? 32'h0000_ffff : 32'hffff_0000;
        else
        begin
            unique case (sel)
                2'b00: m = 32'hff00_0000;
                2'b01: m = 32'h00ff_0000;
                2'b10: m = 32'h0000_ff00;
                2'b11: m = 32'h0000_00ff;
            endcase
        end
        return m;
    endfunction

    // byte offset compare, shared by the commit decoders and the rx pop decoder
    function automatic logic at_off(input logic [7:0] a,
                                    input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic [15:0] lane_pick(input logic [31:0] q,
                                              input logic b16,
                                              input logic [1:0] sel);
        logic [15:0] r;
        r = 16'h0000;
        if (b16)
            r = sel[1] ? q[15:0] : q[31:16];
        else
        begin
            unique case (sel)
                2'b00: r = {8'h00, q[31:24]};
                2'b01: r = {8'h00, q[23:16]};
                2'b10: r = {8'h00, q[15:8]};
                2'b11: r = {8'h00, q[7:0]};
            endcase
        end
        return r;
    endfunction

    wire logic rd_act     = ~host_req.cs_n & ~host_req.rd_n;
    wire logic wr_act     = ~host_req.cs_n & ~host_req.wr_n;
    wire logic upd_line   = host_req.addr[8];
    wire logic pwr_down   = power_reg[`HSR_BIT_SOFT_PD] | powerdown_pin;
    wire logic is_power   = (byte_addr == `HSR_OFF_POWER);
    wire logic access_ok  = ~pwr_down | is_power;  // see [R25]
    wire logic rd_start   = rd_act & (acc_state != HSR_READ) & access_ok;
    wire logic wr_start   = wr_act & (acc_state != HSR_WRITE) & access_ok;
    wire logic snap       = rd_start & upd_line & ~is_power;
    wire logic commit     = wr_start & upd_line & ~is_power;
    wire logic [5:0] idx  = host_req.addr[7:2];

    assign byte_addr = {idx, 2'b00};

    // strobe tracker: a held strobe starts one access, not one per edge
    always_comb
    begin
        next_acc_state = HSR_IDLE;
        unique case (acc_state)
            HSR_IDLE:
            begin
                if (rd_act)
                    next_acc_state = HSR_READ;
                else if (wr_act)
                    next_acc_state = HSR_WRITE;
            end
            HSR_READ:
            begin
                if (rd_act)
                    next_acc_state = HSR_READ;
                else if (wr_act)
                    next_acc_state = HSR_WRITE;
            end
            HSR_WRITE:
            begin
                if (wr_act)
                    next_acc_state = HSR_WRITE;
                else if (rd_act)
                    next_acc_state = HSR_READ;
            end
            default:
                next_acc_state = HSR_IDLE;   // 2'b11 is an illegal code
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_state <= HSR_IDLE;
        else
            acc_state <= next_acc_state;
    end

    // indexed register value fetched for a snapshot
    always_comb
    begin
        target_val = 32'h0000_0000;
        case (byte_addr)
            `HSR_OFF_STAGING:
                target_val = staging;
            `HSR_OFF_IND_INDEX:
                target_val = ind_index;
            `HSR_OFF_IND_WINDOW:
                target_val = ind_reg[ind_index[3:0]];   // see [R8]
            `HSR_OFF_FIFO_XFER:
                target_val = rx_head.data;               // see [R26]
            default:
                if (idx < 6'(`HSR_GEN_COUNT))
                    target_val = gen_reg[idx];
        endcase
    end

    // lane placement of host write data
    always_comb
    begin
        lane_mask = lane_bits(bus16_mode, host_req.addr[1:0]); // see [R10] [R11]
        lane_data = bus16_mode ? {2{host_req.data}}
                               : {4{host_req.data[7:0]}};
        // one lane (8-bit) or one half (16-bit) only, others kept from staging
        next_staging = (staging & ~lane_mask) | (lane_data & lane_mask); // see [R12] [R13] [R14]
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            staging <= `HSR_STAGING_RESET;              // see [R24]
        else if (snap)
            staging <= target_val;                      // see [R4] [R16]
        else if (wr_start && !is_power)
            staging <= next_staging;                    // see [R14]
    end

    // commit writes the assembled quadlet in a single cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ind_index <= 32'h0000_0000;
        else if (commit && at_off(byte_addr, `HSR_OFF_IND_INDEX))
            ind_index <= next_staging;                  // see [R9] [R8]
    end

    generate
        for (genvar g = 0; g < `HSR_GEN_COUNT; g++)
        begin : g_gen
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    gen_reg[g] <= 32'h0000_0000;
                else if (commit && idx == 6'(g))
                    gen_reg[g] <= next_staging;         // see [R9] [R16]
            end
        end
        for (genvar k = 0; k < `HSR_IND_COUNT; k++)
        begin : g_ind
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    ind_reg[k] <= 32'h0000_0000;
                else if (commit && at_off(byte_addr, `HSR_OFF_IND_WINDOW)
                         && ind_index[3:0] == 4'(k))
                    ind_reg[k] <= next_staging;         // see [R8]
            end
        end
    endgenerate

    // receive head moves into staging and leaves the queue
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rx_pop <= 1'b0;
        else
            rx_pop <= snap && at_off(byte_addr, `HSR_OFF_FIFO_XFER)
                      && rx_head.valid;                 // see [R26] [R15]
    end

    // transfer register drains to the tx fifo without the host
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_out <= '0;
        else if (commit && at_off(byte_addr, `HSR_OFF_FIFO_XFER))
        begin
            tx_out.valid <= 1'b1;                       // see [R15]
            tx_out.data  <= next_staging;
        end
        else if (tx_ready)
            tx_out.valid <= 1'b0;
    end

    // stretch updating accesses while the quadlet moves
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_extend <= 1'b0;
            wait_cnt    <= 3'b000;
        end
        else if ((snap || commit) && !wait_extend)
        begin
            wait_extend <= 1'b1;                        // see [R23]
            wait_cnt    <= WAIT_CYC - 3'd2;
        end
        else if (wait_extend)
        begin
            // transfer takes one cycle; never beyond the cap
            wait_extend <= 1'b0;
            wait_cnt    <= (wait_cnt == 3'b000) ? 3'b000 : wait_cnt - 3'd1;
        end
    end

    // power register: status mirrors, sticky flags, enables, control
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            power_reg <= `HSR_POWER_RESET;
        else
        begin
            if (wr_start && is_power)
            begin
                for (int i = 8; i < 32; i++)
                    if (lane_mask[i])
                        power_reg[i] <= lane_data[i];   // see [R21] [R22]
                for (int i = `HSR_BIT_CLK_IDLE; i <= `HSR_BIT_CLK_ACT; i++)
                    if (lane_mask[i] && lane_data[i])
                        power_reg[i] <= 1'b0;           // see [R20] [R19]
            end
            // set wins over a same-cycle acknowledge
            if (clock_idle)
                power_reg[`HSR_BIT_CLK_IDLE] <= 1'b1;   // see [R19]
            if (phy_link_evt)
                power_reg[`HSR_BIT_PHY_LINK] <= 1'b1;   // see [R20]
            if (link_on_evt)
                power_reg[`HSR_BIT_LINK_ON] <= 1'b1;    // see [R20]
            if (clk_act_evt)
                power_reg[`HSR_BIT_CLK_ACT] <= 1'b1;    // see [R20]
            power_reg[`HSR_BIT_LPS_STATE] <= 1'b0;
        end
    end

    // status bit taken live so it follows lps without the clock
    always_comb
    begin
        power_view = power_reg;
        power_view[`HSR_BIT_LPS_STATE] = lps_active;    // see [R18]
    end

    // flag and enable pairs that may raise the host interrupt
    generate
        for (genvar s = 0; s < 3; s++)
        begin : g_irq
            assign irq_src[s] = power_reg[`HSR_BIT_PHY_LINK + s]
                                & power_reg[`HSR_BIT_EN_PHY_LINK + s];
        end
    endgenerate

    // idle flag pairs with an enable outside the run of the others
    assign irq_src[3] = power_reg[`HSR_BIT_CLK_IDLE]
                        & power_reg[`HSR_BIT_EN_CLK_IDLE];

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_irq_n <= 1'b1;
            lps_drive  <= 1'b0;
        end
        else
        begin
            host_irq_n <= ~|irq_src;                    // see [R27] [R21]
            // pin is not folded into the soft bit
            lps_drive  <= ~pwr_down;                    // see [R22]
        end
    end

    // lane mux is combinational so lane lines may toggle in one read
    always_comb
    begin
        host_rdata_oe = rd_act & access_ok;
        if (is_power)
            host_rdata = lane_pick(power_view, bus16_mode,
                                   host_req.addr[1:0]); // see [R17]
        else if (access_ok)
            host_rdata = lane_pick(staging, bus16_mode,
                                   host_req.addr[1:0]); // see [R1] [R2] [R3] [R5] [R6] [R7]
        else
            host_rdata = 16'h0000;
    end

endmodule
`default_nettype wire

// File: tb/hsr_host_port_properties.sv
// concurrent checks on the host shadow register access port
`timescale 1ns/10ps
`default_nettype none
module hsr_host_port_properties
    import hsr_pkg::*;
(
    input wire logic          sys_clk,       // clock
    input wire logic          rst_n,         // reset, low
    input wire hsr_host_req_t host_req,      // host pins
    input wire logic   [15:0] host_rdata,    // read data
    input wire logic          host_rdata_oe, // data enable
    input wire logic          wait_extend,   // stretch
    input wire logic          host_irq_n,    // irq, low
    input wire logic          powerdown_pin, // power-down pin
    input wire logic          lps_drive,     // lps out
    input wire hsr_quad_t     rx_head,       // rx queue head
    input wire logic          rx_pop,        // rx pop
    input wire hsr_quad_t     tx_out,        // tx quadlet
    input wire logic          tx_ready       // tx accepts
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic act;
    assign act = !host_req.cs_n && !(host_req.rd_n && host_req.wr_n);
    property p_wait_on;
        act && !$past(act) && host_req.addr[8] && lps_drive |=> wait_extend;
    endproperty
    a_wait_on: assert property (p_wait_on) else $error("no wait");
    property p_wait_one; wait_extend |=> !wait_extend; endproperty
    a_wait_one: assert property (p_wait_one) else $error("long wait");
    // power register bits are live, so they are left out here
    property p_hold;
        !host_req.cs_n && !host_req.rd_n && !host_req.addr[8] && $past(act)
        && host_req.addr[7:2] != 6'h2c && $stable(host_req.addr)
        |-> $stable(host_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_refuse;
        !host_req.cs_n && !host_req.rd_n && !lps_drive
        && host_req.addr[7:2] != 6'h2c |-> !host_rdata_oe && host_rdata == 0;
    endproperty
    a_refuse: assert property (p_refuse) else $error("not refused");
    property p_irq; host_req.wr_n [*3] ##0 !host_irq_n |=> !host_irq_n;
    endproperty
    a_irq: assert property (p_irq) else $error("irq lost");
    property p_pin; powerdown_pin |=> !lps_drive; endproperty
    a_pin: assert property (p_pin) else $error("lps driven");
    property p_pop;
        act && !$past(act) && !host_req.rd_n && host_req.addr == 9'h1c0
        && rx_head.valid && lps_drive |-> ##[1:2] rx_pop;
    endproperty
    a_pop: assert property (p_pop) else $error("no pop");
    property p_tx; tx_out.valid && !tx_ready |=> tx_out.valid; endproperty
    a_tx: assert property (p_tx) else $error("tx dropped");
    c_wait: cover property (wait_extend);
    c_pop: cover property (rx_pop);
    c_irq: cover property (!host_irq_n);
endmodule
bind hsr_host_port hsr_host_port_properties u_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .host_req(host_req),
    .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
    .wait_extend(wait_extend), .host_irq_n(host_irq_n),
    .powerdown_pin(powerdown_pin), .lps_drive(lps_drive),
    .rx_head(rx_head), .rx_pop(rx_pop), .tx_out(tx_out),
    .tx_ready(tx_ready));
`default_nettype wire

// File: tb/hsr_host_model.sv
// host cpu bus master facing the port
`timescale 1ns/10ps
`default_nettype none
module hsr_host_model
    import hsr_pkg::*;
(
    input  wire logic        sys_clk, // clock
    output var hsr_host_req_t req      // host pins
);
    initial
    begin
        req = '{1'b1, 1'b1, 1'b1, 9'h000, 16'h0000};
    end
    // index and update line sit with the strobe until after the taking edge
    task automatic go(input logic w, input logic [8:0] a,
                      input logic [15:0] d);
        @(negedge sys_clk);
        req <= '{1'b0, w, !w, a, d};
        @(posedge sys_clk);
    endtask
    task automatic lane(input logic [1:0] l);
        @(negedge sys_clk);
        req.addr[1:0] <= l;
    endtask
    // released data lines flip so no stale value looks valid
    task automatic stop;
        @(negedge sys_clk);
        req.cs_n <= 1'b1;
        req.rd_n <= 1'b1;
        req.wr_n <= 1'b1;
        req.data <= ~req.data;
    endtask
endmodule
`default_nettype wire

// File: tb/test_hsr_host_port.sv
// self-checking bench for the host shadow register access port
`timescale 1ns/10ps
`default_nettype none
`include "hsr_cfg.svh"
module test_hsr_host_port import hsr_pkg::*;;
    localparam logic [31:0] PRE = `HSR_STAGING_RESET;
    logic          sys_clk       = 1'b0;
    logic          rst_n         = 1'b0;
    logic          bus16_mode    = 1'b0;
    logic          powerdown_pin = 1'b0;
    logic          tx_ready      = 1'b0;
    logic          lps_active    = 1'b1;
    logic    [3:0] evt           = 4'h0;
    hsr_quad_t     rx_head       = '0;
    hsr_host_req_t host_req;
    logic   [15:0] host_rdata;
    logic          host_irq_n;
    logic          lps_drive;
    hsr_quad_t     tx_out;
    int            n_mismatch      = 0;
    int            samples_checked = 0;
    hsr_host_port u_hsr_host_port (.sys_clk(sys_clk), .rst_n(rst_n),
        .host_req(host_req), .bus16_mode(bus16_mode),
        .host_rdata(host_rdata), .host_rdata_oe(), .wait_extend(),
        .host_irq_n(host_irq_n), .lps_active(lps_active), .clock_idle(evt[0]),
        .phy_link_evt(evt[3]), .link_on_evt(evt[2]), .clk_act_evt(evt[1]),
        .powerdown_pin(powerdown_pin), .lps_drive(lps_drive),
        .rx_head(rx_head), .rx_pop(), .tx_out(tx_out), .tx_ready(tx_ready));
    hsr_host_model u_hsr_host_model (.sys_clk(sys_clk), .req(host_req));
    always #10 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // extra idle edge lets registered flags settle before the next look
    task automatic acc(input logic w, input logic [8:0] a,
                       input logic [15:0] d);
        u_hsr_host_model.go(w, a, d);
        #1;
        if (!w)
            chk("rdata", 33'(host_rdata), 33'(d));
        u_hsr_host_model.stop();
        @(negedge sys_clk);
    endtask
    task automatic results;
        $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (4000) @(posedge sys_clk);
        n_mismatch++;
        results();
    end
    initial
    begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        u_hsr_host_model.go(1'b0, 9'h0f7, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            u_hsr_host_model.lane(2'(i));
            #1 chk("lane", 33'(host_rdata), 33'(PRE[31-8*i -: 8]));
        end
        u_hsr_host_model.stop();
        bus16_mode = 1'b1;
        acc(1, 9'h054, 16'h1234);
        acc(1, 9'h156, 16'h5678);
        acc(0, 9'h158, 16'h0000);
        acc(0, 9'h154, 16'h1234);
        acc(0, 9'h056, 16'h5678);
        bus16_mode = 1'b0;
        acc(1, 9'h054, 16'hff11);
        acc(1, 9'h054, 16'hffaa);
        acc(1, 9'h157, 16'hff44);
        acc(0, 9'h158, 16'h0000);
        acc(0, 9'h156, 16'h0056);
        acc(0, 9'h157, 16'h0044);
        acc(1, 9'h156, 16'h0077);
        acc(0, 9'h158, 16'h0000);
        acc(0, 9'h154, 16'h00aa);
        acc(0, 9'h056, 16'h0077);
        acc(1, 9'h1fb, 16'h0003);
        acc(1, 9'h1ff, 16'h009c);
        acc(1, 9'h1fb, 16'h0004);
        acc(0, 9'h1ff, 16'h0000);
        acc(1, 9'h1fb, 16'h0003);
        acc(0, 9'h1ff, 16'h009c);
        rx_head = '{1'b1, 32'hcafe_0001};
        acc(0, 9'h1c0, 16'h00ca);
        rx_head = '0;
        acc(1, 9'h1c3, 16'h005a);
        chk("tx", 33'(tx_out), {1'b1, 32'hcafe_005a});
        tx_ready = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("txv", 33'(tx_out.valid), 33'h0);
        acc(0, 9'h0b3, 16'h0001);
        evt = 4'hf;
        @(negedge sys_clk);
        evt = 4'h0;
        acc(0, 9'h0b3, 16'h001f);
        acc(1, 9'h0b2, 16'h0001);
        chk("irq", 33'(host_irq_n), 33'h0);
        acc(1, 9'h0b3, 16'h001e);
        acc(0, 9'h0b3, 16'h0001);
        chk("irq", 33'(host_irq_n), 33'h1);
        lps_active = 1'b0;
        acc(0, 9'h0b3, 16'h0000);
        lps_active = 1'b1;
        acc(1, 9'h0b1, 16'h0001);
        chk("lps", 33'(lps_drive), 33'h0);
        acc(0, 9'h0f4, 16'h0000);
        acc(1, 9'h0b1, 16'h0000);
        powerdown_pin = 1'b1;
        acc(0, 9'h0b1, 16'h0000);
        chk("lps", 33'(lps_drive), 33'h0);
        results();
    end
endmodule
`default_nettype wire
